//--- design/ows_map.vh
// timing constants for the single-wire slot generator
`ifndef OWS_MAP_VH
`define OWS_MAP_VH
// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define OWS_CLK_MHZ        125
// ---------------------------------------------------------------
// times in microseconds, normal speed
// ---------------------------------------------------------------
`define OWS_T_STAGGER_US   2
`define OWS_T_SLOT_US      60
`define OWS_T_RST_LOW_US   480
`define OWS_T_RST_BUSY_US  960
`define OWS_T_ALARM_US     3840
`define OWS_T_BIT_LOW_US   1
`define OWS_T_W0_LOW_US    60
`define OWS_T_SAMPLE_US    15
// ---------------------------------------------------------------
// overdrive times (values chosen, scaled about by ten)
// ---------------------------------------------------------------
`define OWS_T_OD_SLOT_US   6
`define OWS_T_OD_RST_US    48
`define OWS_T_OD_BUSY_US   96
`define OWS_T_OD_W0_US     6
`define OWS_T_OD_SMP_US    2
`endif

//--- design/ows_slot_gen.v
// single-wire bus master slot timing generator, device side
`timescale 1ns/1ps
`include "ows_map.vh"
module ows_slot_gen #(
  parameter integer T_RST_BUSY = `OWS_T_RST_BUSY_US * `OWS_CLK_MHZ, // reset busy cycles
  parameter integer T_ALARM    = `OWS_T_ALARM_US * `OWS_CLK_MHZ     // alarm wait cycles
) (
  input  wire clk,                   // system clock, 125 MHz
  input  wire arst_n,                // async reset, active low
  input  wire enable_in_n,           // slot frame from host, active low
  input  wire slot_type_and_query,   // slot type, later result query
  input  wire bus_clear_request_n,   // low requests a bus reset, or with select low an overdrive toggle
  input  wire pass_in1,              // downstream input 1
  input  wire pass_in2,              // downstream input 2
  input  wire line_in,               // single-wire line level
  output reg  line_out,              // line output value (always 0)
  output reg  line_oe_n,             // line drive enable, low drives
  output reg  out1_busy1_n,          // output 1 / busy 1
  output reg  out2_busy2_n,          // output 2 / busy 2
  output reg  enable_out_n_out,      // enable out value (always 0)
  output reg  enable_out_n_oe_n,     // enable out drive, low pulls low
  output reg  fast_timing_flag       // overdrive state
);
  // ---------------------------------------------------------------
  // derived cycle counts
  // ---------------------------------------------------------------
  localparam integer C_STAG  = `OWS_T_STAGGER_US * `OWS_CLK_MHZ;
  localparam integer C_SLOT  = `OWS_T_SLOT_US * `OWS_CLK_MHZ;
  localparam integer C_RLOW  = `OWS_T_RST_LOW_US * `OWS_CLK_MHZ;
  localparam integer C_B1    = `OWS_T_BIT_LOW_US * `OWS_CLK_MHZ;
  localparam integer C_W0    = `OWS_T_W0_LOW_US * `OWS_CLK_MHZ;
  localparam integer C_SMP   = `OWS_T_SAMPLE_US * `OWS_CLK_MHZ;
  localparam integer C_OSLOT = `OWS_T_OD_SLOT_US * `OWS_CLK_MHZ;
  localparam integer C_ORST  = `OWS_T_OD_RST_US * `OWS_CLK_MHZ;
  localparam integer C_OBUSY = `OWS_T_OD_BUSY_US * `OWS_CLK_MHZ;
  localparam integer C_OW0   = `OWS_T_OD_W0_US * `OWS_CLK_MHZ;
  localparam integer C_OSMP  = `OWS_T_OD_SMP_US * `OWS_CLK_MHZ;
  localparam integer TW      = 20;   // timer width, fits 3840us
  // ---------------------------------------------------------------
  // one-hot states
  // ---------------------------------------------------------------
  localparam [7:0] S_IDLE  = 8'h01;  // enable high, pass through
  localparam [7:0] S_BLOW  = 8'h02;  // bit slot, line driven low
  localparam [7:0] S_BREC  = 8'h04;  // bit slot, released, sampling
  localparam [7:0] S_RLOW  = 8'h08;  // reset low pulse
  localparam [7:0] S_ALRM  = 8'h10;  // waiting for a stuck line
  localparam [7:0] S_PRES  = 8'h20;  // presence watch, busy hold
  localparam [7:0] S_DONE  = 8'h40;  // slot over, result on query
  localparam [7:0] S_TOGL  = 8'h80;  // overdrive toggled, frame open
  // ---------------------------------------------------------------
  // input synchronisers; first stage read only by the second
  // ---------------------------------------------------------------
  reg [5:0] sync1;                   // first stage
  reg [5:0] sync2;                   // second stage, used by logic
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 6'h3f;
      sync2 <= 6'h3f;
    end else begin
      sync1 <= {enable_in_n, slot_type_and_query, bus_clear_request_n,
                pass_in1, pass_in2, line_in};
      sync2 <= sync1;
    end
  end
  wire en_n  = sync2[5];             // synchronised enable
  wire query = sync2[4];             // synchronised select/query
  wire req_n = sync2[3];             // synchronised reset request
  wire pin1  = sync2[2];             // synchronised pass input 1
  wire pin2  = sync2[1];             // synchronised pass input 2
  wire line  = sync2[0];             // synchronised line level
  reg  en_d;                         // enable, one cycle late
  wire en_fall = en_d & ~en_n;       // frame start
  // ---------------------------------------------------------------
  // state and slot registers
  // ---------------------------------------------------------------
  reg  [7:0]    state;               // current state
  reg  [7:0]    next_state;          // next state
  reg           lat_query;           // latched select
  reg           lat_req_n;           // latched reset request
  reg           result;              // sampled slot result
  reg           seen_rise;           // line rose after reset low
  reg           ds_busy;             // downstream busy seen in reset
  reg           is_last;             // this device is last on port
  reg  [TW-1:0] slot_cnt;            // cycles since slot start
  reg           stag;                // 2us stagger elapsed
  reg           load;                // timer load strobe
  reg  [TW-1:0] load_val;            // timer load value
  wire          t_done;              // timer elapsed
  wire          od = fast_timing_flag;
  // separate speed tables, picked by the flag
  wire [TW-1:0] c_slot = od ? C_OSLOT[TW-1:0] : C_SLOT[TW-1:0];
  wire [TW-1:0] c_rlow = od ? C_ORST[TW-1:0]  : C_RLOW[TW-1:0];
  wire [TW-1:0] c_busy = od ? C_OBUSY[TW-1:0] : T_RST_BUSY[TW-1:0];
  wire [TW-1:0] c_w0   = od ? C_OW0[TW-1:0]   : C_W0[TW-1:0];
  wire [TW-1:0] c_smp  = od ? C_OSMP[TW-1:0]  : C_SMP[TW-1:0];
  ows_timer #(.W(TW)) u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .load   (load),
    .value  (load_val),
    .done   (t_done)
  );
  // ---------------------------------------------------------------
  // next-state logic and timer loads
  // ---------------------------------------------------------------
  always @* begin
    next_state = state;
    load       = 1'b0;
    load_val   = {TW{1'b0}};
    case (state)
      S_IDLE: begin
        if (en_fall) begin
          if (!query && !req_n) begin
            next_state = S_TOGL;
          end else if (!req_n) begin
            next_state = S_RLOW;
            load       = 1'b1;
            load_val   = c_rlow;
          end else begin
            next_state = S_BLOW;
            load       = 1'b1;
            load_val   = query ? C_B1[TW-1:0] : c_w0;
          end
        end
      end
      S_BLOW: begin
        if (t_done) begin
          next_state = S_BREC;
        end
      end
      S_BREC: begin
        // busy released only once the full slot has run
        if (slot_cnt >= c_slot && line) begin
          next_state = S_DONE;
        end
      end
      S_RLOW: begin
        if (t_done) begin
          next_state = S_ALRM;
          load       = 1'b1;
          load_val   = T_ALARM[TW-1:0];
        end
      end
      S_ALRM: begin
        if (line) begin
          next_state = S_PRES;
        end else if (t_done) begin
          next_state = S_DONE;
        end
      end
      S_PRES: begin
        if (slot_cnt >= c_busy && line) begin
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        if (en_n) begin
          next_state = S_IDLE;
        end
      end
      S_TOGL: begin
        if (en_n) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (en_n && state != S_IDLE && state != S_DONE && state != S_TOGL &&
        state != S_RLOW && state != S_ALRM && state != S_PRES &&
        state != S_BLOW && state != S_BREC) begin
      next_state = S_IDLE;
    end
  end
  // ---------------------------------------------------------------
  // sequential slot bookkeeping
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state            <= S_IDLE;
      en_d             <= 1'b1;
      lat_query        <= 1'b1;
      lat_req_n        <= 1'b1;
      result           <= 1'b1;
      seen_rise        <= 1'b0;
      ds_busy          <= 1'b0;
      is_last          <= 1'b0;
      slot_cnt         <= {TW{1'b0}};
      stag             <= 1'b0;
      fast_timing_flag <= 1'b0;
    end else begin
      state <= next_state;
      en_d  <= en_n;
      if (en_fall && state == S_IDLE) begin
        lat_query <= query;
        lat_req_n <= req_n;
        slot_cnt  <= {TW{1'b0}};
        stag      <= 1'b0;
        result    <= 1'b1;
        seen_rise <= 1'b0;
        ds_busy   <= 1'b0;
        if (!query && !req_n) begin
          fast_timing_flag <= ~fast_timing_flag;
        end
      end else if (slot_cnt != {TW{1'b1}}) begin
        slot_cnt <= slot_cnt + 1'b1;
      end
      // the count is stale at a slot start; it must not re-arm the
      // stagger in the same cycle that clears it
      if (slot_cnt >= C_STAG[TW-1:0] && !(en_fall && state == S_IDLE)) begin
        stag <= 1'b1;
      end
      // bit slot result taken at the sample instant; a write zero is
      // still in its low phase then, so both phases must be covered
      if ((state == S_BLOW || state == S_BREC) && slot_cnt == c_smp) begin
        result <= line;
      end
      // presence: any low after the line first rose
      if (state == S_PRES) begin
        seen_rise <= 1'b1;
        if (!line && seen_rise) begin
          result <= 1'b0;
        end
      end
      // downstream busy during reset marks a cascade behind us
      if ((state == S_RLOW) && (!pin1 || !pin2)) begin
        ds_busy <= 1'b1;
      end
      if (state == S_PRES && next_state == S_DONE) begin
        is_last <= ~ds_busy;
      end
    end
  end
  // ---------------------------------------------------------------
  // output drivers, all registered
  // ---------------------------------------------------------------
  wire busy_st = (state == S_BLOW) | (state == S_BREC) | (state == S_RLOW) |
                 (state == S_ALRM) | (state == S_PRES);
  wire in1 = is_last ? 1'b1 : pin1;  // ignored inputs read high
  wire in2 = is_last ? 1'b1 : pin2;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out1_busy1_n      <= 1'b1;
      out2_busy2_n      <= 1'b1;
      line_out          <= 1'b0;
      line_oe_n         <= 1'b1;
      enable_out_n_out  <= 1'b0;
      enable_out_n_oe_n <= 1'b1;
    end else begin
      line_out <= 1'b0;
      // line pulled low only during the low phases, never on toggle
      line_oe_n <= ~((next_state == S_BLOW) | (next_state == S_RLOW));
      // enable passes on except while this device is marked last (is_last)
      enable_out_n_out  <= 1'b0;
      enable_out_n_oe_n <= is_last ? 1'b1 : en_n;
      if (en_n) begin
        out1_busy1_n <= pin1;
        out2_busy2_n <= pin2;
      end else if (state == S_IDLE) begin
        // frame open but slot not started yet; a last device must not
        // let its pass inputs through here either
        out1_busy1_n <= in1;
        out2_busy2_n <= in2;
      end else if (busy_st) begin
        out1_busy1_n <= 1'b0;
        out2_busy2_n <= (!lat_req_n && !stag) ? 1'b1 : 1'b0;
      end else if (state == S_TOGL) begin
        out1_busy1_n <= od ? in1 : 1'b0;
        out2_busy2_n <= od ? in2 : 1'b0;
      end else if (!query && !result) begin
        out1_busy1_n <= 1'b0;
        out2_busy2_n <= 1'b0;
      end else begin
        out1_busy1_n <= in1;
        out2_busy2_n <= in2;
      end
    end
  end
endmodule // ows_slot_gen

//--- design/ows_timer.v
// down-counting interval timer with a done flag
`timescale 1ns/1ps
module ows_timer #(
  parameter W = 20                   // counter width
) (
  input  wire         clk,           // system clock
  input  wire         arst_n,        // async reset, active low
  input  wire         load,          // load a new interval
  input  wire [W-1:0] value,         // interval in cycles
  output reg          done           // high once the interval elapsed
);
  reg [W-1:0] count;                 // cycles remaining
  // ---------------------------------------------------------------
  // count down; done rises when zero is reached
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {W{1'b0}};
      done  <= 1'b1;
    end else if (load) begin
      count <= value;
      done  <= 1'b0;
    end else if (count != {W{1'b0}}) begin
      count <= count - 1'b1;
      done  <= (count == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule // ows_timer

//--- verification/ows_slot_gen_props.sv
// port checker for the single-wire slot generator
`timescale 1ns/1ps
module ows_slot_gen_props #(
  parameter integer T_RST_BUSY = 120000, // reset busy cycles
  parameter integer T_ALARM    = 480000  // alarm wait cycles
) (
  input wire clk,
  input wire arst_n,
  input wire enable_in_n,
  input wire slot_type_and_query,
  input wire bus_clear_request_n,
  input wire pass_in1,
  input wire pass_in2,
  input wire line_in,
  input wire line_out,
  input wire line_oe_n,
  input wire out1_busy1_n,
  input wire out2_busy2_n,
  input wire enable_out_n_out,
  input wire enable_out_n_oe_n,
  input wire fast_timing_flag
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  reg [19:0] slot_cnt; // cycles since enable fell
  reg [19:0] low_cnt;  // cycles the line drive is on
  reg        rst_seen; // staggered busy seen in frame
  reg        tog;      // flag changed in frame
  reg        flag_q;   // flag one cycle ago
  // the slot counter and frame flags use the raw enable, so they lead the synchronised slot start
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_cnt <= 20'h0;
      low_cnt  <= 20'h0;
      rst_seen <= 1'b0;
      tog      <= 1'b0;
      flag_q   <= 1'b0;
    end else begin
      slot_cnt <= enable_in_n ? 20'h0 : slot_cnt + 20'h1;
      low_cnt  <= line_oe_n ? 20'h0 : low_cnt + 20'h1;
      rst_seen <= !enable_in_n && (rst_seen || (!out1_busy1_n && out2_busy2_n));
      tog      <= !enable_in_n && (tog || (fast_timing_flag != flag_q));
      flag_q   <= fast_timing_flag;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_pass_idle: assert property ((enable_in_n && $stable(pass_in1) && $stable(pass_in2))[*6]
    |-> out1_busy1_n == pass_in1 && out2_busy2_n == pass_in2) else $error("idle pass mismatch");
  a_bit_together: assert property (!enable_in_n && bus_clear_request_n && $fell(out1_busy1_n)
    && $past(out2_busy2_n) |-> !out2_busy2_n) else $error("bit busy not together");
  a_reset_stagger: assert property (!enable_in_n && $fell(out1_busy1_n) && out2_busy2_n
    |-> ##[240:260] !out2_busy2_n) else $error("reset stagger wrong");
  a_busy_hold: assert property (!enable_in_n && !tog && !fast_timing_flag && slot_cnt > 20'd16
    && (slot_cnt < 20'd7500 || (rst_seen && slot_cnt < T_RST_BUSY)) |-> !out1_busy1_n)
    else $error("busy released early");
  a_reset_low_len: assert property ($rose(line_oe_n) && rst_seen && !fast_timing_flag
    |-> low_cnt >= 20'd60000) else $error("reset low too short");
  a_slot_low_len: assert property ($rose(line_oe_n) && !rst_seen && !fast_timing_flag
    |-> low_cnt >= 20'd125) else $error("slot low too short");
  a_toggle_quiet: assert property ($changed(fast_timing_flag)
    |-> line_oe_n && $past(line_oe_n) && $past(line_oe_n, 2)) else $error("toggle hit line");
  a_enable_idle: assert property (enable_in_n[*6] |-> enable_out_n_oe_n)
    else $error("enable out pulled while idle");
  a_drive_zero: assert property (line_out == 1'b0 && enable_out_n_out == 1'b0)
    else $error("open drain value not zero");
  c_reset: cover property (rst_seen && $rose(line_oe_n));
  c_toggle: cover property ($rose(fast_timing_flag));
  c_bit: cover property ($rose(line_oe_n) && !rst_seen);
endmodule // ows_slot_gen_props
bind ows_slot_gen ows_slot_gen_props #(.T_RST_BUSY(T_RST_BUSY), .T_ALARM(T_ALARM))
  i_ows_slot_gen_props (.clk(clk), .arst_n(arst_n), .enable_in_n(enable_in_n),
  .slot_type_and_query(slot_type_and_query), .bus_clear_request_n(bus_clear_request_n),
  .pass_in1(pass_in1), .pass_in2(pass_in2), .line_in(line_in), .line_out(line_out),
  .line_oe_n(line_oe_n), .out1_busy1_n(out1_busy1_n), .out2_busy2_n(out2_busy2_n),
  .enable_out_n_out(enable_out_n_out), .enable_out_n_oe_n(enable_out_n_oe_n),
  .fast_timing_flag(fast_timing_flag));

//--- verification/ows_wire_slave.sv
// behavioural single-wire slave on the far side of the line
`timescale 1ns/1ps
module ows_wire_slave #(
  parameter integer T_PRES = 1875        // presence delay, 15us
) (
  input  wire clk,                       // system clock
  input  wire line,                      // resolved line level
  input  wire read_zero,                 // answer the next bit slot with zero
  output reg  pull                       // high pulls the line low
);
  integer   low_n;                       // cycles the line has been low
  integer   t;                           // cycles into the current answer
  reg       line_q;                      // line one cycle ago
  reg [1:0] st;                          // idle, wait, presence, zero hold
  initial begin
    pull = 1'b0;
    low_n = 0;
    t = 0;
    line_q = 1'b1;
    st = 2'h0;
  end
  // a long low then a rise is a reset; a short fall is a bit slot
  always @(posedge clk) begin
    line_q <= line;
    low_n <= line ? 0 : low_n + 1;
    t <= t + 1;
    case (st)
      2'h0: if (line_q && !line && read_zero) begin
        st <= 2'h3;
        pull <= 1'b1;
        t <= 0;
      end else if (!line_q && line && low_n > 50000) begin
        st <= 2'h1;
        t <= 0;
      end
      2'h1: if (t == T_PRES) begin
        st <= 2'h2;
        pull <= 1'b1;
        t <= 0;
      end
      2'h2: if (t == 4 * T_PRES) begin
        st <= 2'h0;
        pull <= 1'b0;
      end
      default: if (t == 3750) begin      // held past the sample instant
        st <= 2'h0;
        pull <= 1'b0;
      end
    endcase
  end
endmodule // ows_wire_slave

//--- verification/tb.sv
// self-checking bench for the single-wire slot generator
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic q; logic z; logic p; logic [1:0] res;} ows_row_t;
  reg       clk = 1'b0;                  // 125 MHz
  reg       arst_n = 1'b0;               // async reset
  reg       en_n = 1'b1;                 // frame enable
  reg       stq = 1'b1;                  // type / query
  reg       req_n = 1'b1;                // reset request
  reg       p1 = 1'b1;                   // pass input 1
  reg       p2 = 1'b0;                   // pass input 2
  reg       rz = 1'b0;                   // slave answers zero
  wire      line, pull, lo, loe_n, o1, o2, eoe_n, fl;
  integer   n_fail = 0;
  integer   compares = 0;
  integer   i, n1, k;
  ows_row_t rows [0:2];                  // write one, write zero, read zero
  // open-drain line with pull-up
  assign line = ((!loe_n && !lo) || pull) ? 1'b0 : 1'b1;
  always #4 clk = ~clk;
  // busy hold shortened, but still past the end of the presence pulse
  ows_slot_gen #(.T_RST_BUSY(70000), .T_ALARM(4000)) i_ows_slot_gen (.clk(clk),
    .arst_n(arst_n), .enable_in_n(en_n), .slot_type_and_query(stq),
    .bus_clear_request_n(req_n), .pass_in1(p1), .pass_in2(p2), .line_in(line),
    .line_out(lo), .line_oe_n(loe_n), .out1_busy1_n(o1), .out2_busy2_n(o2),
    .enable_out_n_out(), .enable_out_n_oe_n(eoe_n), .fast_timing_flag(fl));
  ows_wire_slave i_ows_wire_slave (.clk(clk), .line(line), .read_zero(rz), .pull(pull));
  task summarize;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s expected %b seen %b", nm, exp, seen);
      end
    end
  endtask
  // bounded wait for output 1; a timeout ends the run
  task wait_o1(input logic v, input integer lim, output integer n);
    begin
      n = 0;
      while (o1 !== v && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      if (o1 !== v) begin
        chk("wait_o1", {1'b0, o1}, {1'b0, v});
        summarize;
      end
    end
  endtask
  // type set well before the enable fall, so it is latched cleanly
  task frame_start(input logic q, input logic r);
    begin
      @(posedge clk);
      stq <= q;
      req_n <= r;
      repeat (4) @(posedge clk);
      en_n <= 1'b0;
      // type is latched by now; select goes back high so it can query later
      repeat (4) @(posedge clk);
      stq <= 1'b1;
    end
  endtask
  task frame_end;
    begin
      @(posedge clk);
      en_n <= 1'b1;
      stq <= 1'b1;
      req_n <= 1'b1;
      rz <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task query(input logic [1:0] exp);
    begin
      @(posedge clk);
      stq <= 1'b0;
      repeat (8) @(posedge clk);
      chk("result", {o1, o2}, exp);
    end
  endtask
  initial begin
    rows[0] = '{1'b1, 1'b0, 1'b0, 2'b10};
    rows[1] = '{1'b0, 1'b0, 1'b1, 2'b00};
    rows[2] = '{1'b1, 1'b1, 1'b1, 2'b00};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("flag_rst", {1'b0, fl}, 2'b00);
    for (i = 0; i < 3; i = i + 1) begin
      rz <= rows[i].z;
      p2 <= rows[i].p;
      frame_start(rows[i].q, 1'b1);
      wait_o1(1'b0, 20, n1);
      chk("bit_busy", {o1, o2}, 2'b00);
      chk("eno_low", {1'b0, eoe_n}, 2'b00);
      wait_o1(1'b1, 9000, k);
      chk("bit_len", {1'b0, n1 + k >= 7500}, 2'b01);
      query(rows[i].res);
      frame_end;
      chk("idle_pass", {o1, o2}, {1'b1, rows[i].p});
    end
    // overdrive on then off: no slot, flag and outputs only
    frame_start(1'b0, 1'b0);
    repeat (10) @(posedge clk);
    chk("flag_on", {1'b0, fl}, 2'b01);
    chk("od_on", {o1, o2}, 2'b11);
    frame_end;
    frame_start(1'b0, 1'b0);
    repeat (10) @(posedge clk);
    chk("flag_off", {1'b0, fl}, 2'b00);
    chk("od_off", {o1, o2}, 2'b00);
    frame_end;
    // reset with no downstream busy: device becomes last
    p2 <= 1'b1;
    frame_start(1'b1, 1'b0);
    wait_o1(1'b0, 20, n1);
    chk("rst_stag", {o1, o2}, 2'b01);
    repeat (150) @(posedge clk);
    chk("rst_stag2", {o1, o2}, 2'b01);
    repeat (150) @(posedge clk);
    chk("rst_both", {o1, o2}, 2'b00);
    wait_o1(1'b1, 80000, k);
    chk("rst_len", {1'b0, n1 + k >= 69375}, 2'b01);
    query(2'b00);
    frame_end;
    p1 <= 1'b0;
    frame_start(1'b0, 1'b0);
    repeat (10) @(posedge clk);
    chk("eno_last", {1'b0, eoe_n}, 2'b01);
    chk("last_ign", {o1, o2}, 2'b11);
    frame_end;
    chk("pass_last", {o1, o2}, 2'b01);
    summarize;
  end
endmodule // tb
